/* design/spc_pkg.sv */
// constants and types for the switch port command register block
package spc_pkg;

    // register byte offsets
    localparam logic [11:0] SPC_OFF_CMD    = 12'h004;
    localparam logic [11:0] SPC_OFF_STAT   = 12'h040;
    localparam logic [11:0] SPC_OFF_MASK   = 12'h044;

    // command register bit positions
    localparam int SPC_BIT_IO_EN   = 0;
    localparam int SPC_BIT_MEM_EN  = 1;
    localparam int SPC_BIT_BM_EN   = 2;
    localparam int SPC_BIT_PAR_EN  = 6;
    localparam int SPC_BIT_SERR_EN = 8;
    localparam int SPC_BIT_INT_DIS = 10;

    // writable bits of the command register: 0,1,2,6,8,10
    localparam logic [15:0] SPC_CMD_WMASK = 16'h0547;
    localparam logic [15:0] SPC_CMD_RST   = 16'h0000;

    // event status bit positions
    localparam int SPC_EV_UR    = 0;
    localparam int SPC_EV_PAR   = 1;
    localparam int SPC_EV_SERR  = 2;
    localparam int SPC_EV_INTX  = 3;
    localparam int SPC_EV_W     = 4;

    localparam logic [SPC_EV_W-1:0] SPC_STAT_RST = 4'h0;
    localparam logic [SPC_EV_W-1:0] SPC_MASK_RST = 4'h0;

    // axi responses
    localparam logic [1:0] SPC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SPC_RESP_DECERR = 2'h3;

    // a transaction request seen by the port
    typedef struct packed {
        logic is_io;       // 1: i/o space, 0: memory space
        logic non_posted;  // 1: expects a completion
    } spc_req_s;

    // error detection inputs
    typedef struct packed {
        logic parity;
        logic fatal;
        logic nonfatal;
    } spc_err_s;

endpackage

/* design/spc_command_reg.sv */
// switch upstream port command register with request gating and axi4-lite access
`timescale 1ns/1ps
module spc_command_reg
    import spc_pkg::*;
#(
    parameter int ADDR_W = 12
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // primary side requests
    input  wire logic              prim_req_valid,
    input  wire spc_req_s          prim_req,
    output logic                   prim_claim,
    output logic                   prim_ignore,
    // downstream side requests heading upstream
    input  wire logic              dn_req_valid,
    input  wire spc_req_s          dn_req,
    output logic                   up_fwd,
    output logic                   ur_cpl,
    // error detection and reporting
    input  wire spc_err_s          err_det,
    output logic                   par_err_act,
    output logic                   err_fatal_msg,
    output logic                   err_nonfatal_msg,
    // intx messages
    input  wire logic              own_int_req,
    output logic                   own_intx_msg,
    input  wire logic              dn_intx_in,
    output logic                   dn_intx_out,
    // command bits for the rest of the port
    output logic [15:0]            cmd_bits,
    // interrupt
    output logic                   irq
);

    // address match of a register word
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        logic [ADDR_W+11:0] off_x;
        off_x    = {{ADDR_W{1'b0}}, off};
        addr_hit = (a[ADDR_W-1:2] == off_x[ADDR_W-1:2]);
    endfunction

    // byte-enable expansion
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // registers
    logic [15:0]          cmd_q;
    logic [15:0]          cmd_d;
    logic [SPC_EV_W-1:0]  stat_q;
    logic [SPC_EV_W-1:0]  stat_d;
    logic [SPC_EV_W-1:0]  mask_q;
    logic [SPC_EV_W-1:0]  mask_d;

    // write channel holding
    logic                 aw_full_q;
    logic [ADDR_W-1:0]    aw_addr_q;
    logic                 w_full_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;

    // read channel
    logic                 rvalid_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;

    // request and message outputs
    logic                 prim_claim_q;
    logic                 prim_ignore_q;
    logic                 up_fwd_q;
    logic                 ur_cpl_q;
    logic                 par_act_q;
    logic                 fatal_q;
    logic                 nonfatal_q;
    logic                 own_intx_q;
    logic                 dn_intx_q;

    // write decode
    wire                  aw_hs      = s_axi_awvalid & s_axi_awready;
    wire                  w_hs       = s_axi_wvalid & s_axi_wready;
    // fires once both halves are held, whichever came first, and no write response is pending
    wire                  wr_fire    = aw_full_q & w_full_q & ~bvalid_q;
    wire                  wr_cmd     = wr_fire & addr_hit(aw_addr_q, SPC_OFF_CMD);
    wire                  wr_stat    = wr_fire & addr_hit(aw_addr_q, SPC_OFF_STAT);
    wire                  wr_mask    = wr_fire & addr_hit(aw_addr_q, SPC_OFF_MASK);
    wire                  wr_ok      = wr_cmd | wr_stat | wr_mask;
    wire [31:0]           wr_bits    = w_data_q & strb_mask(w_strb_q);
    wire [31:0]           wr_keep    = ~strb_mask(w_strb_q);

    // read decode
    wire                  ar_hs      = s_axi_arvalid & s_axi_arready;
    wire                  rd_cmd     = addr_hit(s_axi_araddr, SPC_OFF_CMD);
    wire                  rd_stat    = addr_hit(s_axi_araddr, SPC_OFF_STAT);
    wire                  rd_mask    = addr_hit(s_axi_araddr, SPC_OFF_MASK);
    wire                  rd_ok      = rd_cmd | rd_stat | rd_mask;
    wire [31:0]           rd_word    = rd_cmd  ? {16'h0000, cmd_q}
                                     : rd_stat ? {{(32-SPC_EV_W){1'b0}}, stat_q}
                                     : rd_mask ? {{(32-SPC_EV_W){1'b0}}, mask_q}
                                     : 32'h0000_0000;

    // command bit views
    wire                  io_en      = cmd_q[SPC_BIT_IO_EN];
    wire                  mem_en     = cmd_q[SPC_BIT_MEM_EN];
    wire                  bm_en      = cmd_q[SPC_BIT_BM_EN];
    wire                  par_en     = cmd_q[SPC_BIT_PAR_EN];
    wire                  serr_en    = cmd_q[SPC_BIT_SERR_EN];
    wire                  int_dis    = cmd_q[SPC_BIT_INT_DIS];

    // primary request gating
    wire                  prim_space = prim_req.is_io ? io_en : mem_en;
    wire                  prim_take  = prim_req_valid & prim_space;
    wire                  prim_drop  = prim_req_valid & ~prim_space;

    // downstream request gating
    wire                  dn_fwd     = dn_req_valid & bm_en;
    wire                  dn_ur      = dn_req_valid & ~bm_en;
    wire                  dn_ur_cpl  = dn_ur & dn_req.non_posted;

    // error and interrupt gating
    wire                  par_go     = err_det.parity & par_en;
    wire                  fatal_go   = err_det.fatal & serr_en;
    wire                  nonfat_go  = err_det.nonfatal & serr_en;
    wire                  intx_go    = own_int_req & ~int_dis;

    // events into status
    wire [SPC_EV_W-1:0]   ev_set     = {intx_go, fatal_go | nonfat_go, par_go, dn_ur};

    // next values of software registers
    always_comb
    begin
        cmd_d  = cmd_q;
        stat_d = stat_q;
        mask_d = mask_q;
        if (wr_cmd)
        begin
            // only the writable bits change; fixed and reserved bits stay zero
            cmd_d = ((cmd_q & wr_keep[15:0]) | wr_bits[15:0]) & SPC_CMD_WMASK;
        end
        if (wr_mask)
        begin
            mask_d = (mask_q & wr_keep[SPC_EV_W-1:0]) | wr_bits[SPC_EV_W-1:0];
        end
        if (wr_stat)
        begin
            stat_d = stat_q & ~wr_bits[SPC_EV_W-1:0];
        end
        // a new event wins over a clear in the same cycle
        stat_d = stat_d | ev_set;
    end

    // software registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_q  <= SPC_CMD_RST;
            stat_q <= SPC_STAT_RST;
            mask_q <= SPC_MASK_RST;
        end
        else
        begin
            cmd_q  <= cmd_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // write address and data holding
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_full_q <= 1'b0;
            end
            if (w_hs)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_full_q <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= SPC_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? SPC_RESP_OKAY : SPC_RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= SPC_RESP_OKAY;
        end
        else if (ar_hs)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_ok ? SPC_RESP_OKAY : SPC_RESP_DECERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // request pulses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prim_claim_q  <= 1'b0;
            prim_ignore_q <= 1'b0;
            up_fwd_q      <= 1'b0;
            ur_cpl_q      <= 1'b0;
        end
        else
        begin
            prim_claim_q  <= prim_take;
            prim_ignore_q <= prim_drop;
            up_fwd_q      <= dn_fwd;
            ur_cpl_q      <= dn_ur_cpl;
        end
    end

    // error and message pulses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            par_act_q     <= 1'b0;
            fatal_q       <= 1'b0;
            nonfatal_q    <= 1'b0;
            own_intx_q    <= 1'b0;
            dn_intx_q     <= 1'b0;
        end
        else
        begin
            par_act_q     <= par_go;
            fatal_q       <= fatal_go;
            nonfatal_q    <= nonfat_go;
            own_intx_q    <= intx_go;
            dn_intx_q     <= dn_intx_in;
        end
    end

    // bus outputs
    assign s_axi_awready    = ~aw_full_q;
    assign s_axi_wready     = ~w_full_q;
    assign s_axi_bvalid     = bvalid_q;
    assign s_axi_bresp      = bresp_q;
    assign s_axi_arready    = ~rvalid_q;
    assign s_axi_rvalid     = rvalid_q;
    assign s_axi_rdata      = rdata_q;
    assign s_axi_rresp      = rresp_q;

    // port outputs
    assign prim_claim       = prim_claim_q;
    assign prim_ignore      = prim_ignore_q;
    assign up_fwd           = up_fwd_q;
    assign ur_cpl           = ur_cpl_q;
    assign par_err_act      = par_act_q;
    assign err_fatal_msg    = fatal_q;
    assign err_nonfatal_msg = nonfatal_q;
    assign own_intx_msg     = own_intx_q;
    assign dn_intx_out      = dn_intx_q;
    assign cmd_bits         = cmd_q;
    assign irq              = |(stat_q & mask_q);

endmodule

/* verif/spc_checker.sv */
// assertions on the command register block ports
`timescale 1ns/1ps
module spc_checker
    import spc_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // requests and events
    input wire logic        prim_req_valid,
    input wire spc_req_s    prim_req,
    input wire logic        dn_req_valid,
    input wire spc_req_s    dn_req,
    input wire spc_err_s    err_det,
    input wire logic        own_int_req,
    input wire logic        dn_intx_in,
    // answers
    input wire logic        prim_claim,
    input wire logic        prim_ignore,
    input wire logic        up_fwd,
    input wire logic        ur_cpl,
    input wire logic        par_err_act,
    input wire logic        err_fatal_msg,
    input wire logic        err_nonfatal_msg,
    input wire logic        own_intx_msg,
    input wire logic        dn_intx_out,
    input wire logic [15:0] cmd_bits
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    io_gate_a: assert property (
        prim_req_valid && prim_req.is_io |=> prim_claim == $past(cmd_bits[0])
        && prim_ignore == !$past(cmd_bits[0])) else $error("io request gating wrong");
    mem_gate_a: assert property (
        prim_req_valid && !prim_req.is_io |=> prim_claim == $past(cmd_bits[1])
        && prim_ignore == !$past(cmd_bits[1])) else $error("memory request gating wrong");
    bm_off_a: assert property (
        dn_req_valid && !cmd_bits[2] |=> !up_fwd && ur_cpl == $past(dn_req.non_posted))
        else $error("request handled wrongly with mastering off");
    bm_on_a: assert property (
        dn_req_valid && cmd_bits[2] |=> up_fwd && !ur_cpl) else $error("request not forwarded");
    fwd_cause_a: assert property (
        up_fwd |-> $past(dn_req_valid) && $past(cmd_bits[2])) else $error("stray forward");
    legacy_zero_a: assert property (
        (cmd_bits & 16'h02b8) == 16'h0000) else $error("hardwired bit set");
    rsvd_zero_a: assert property (
        cmd_bits[15:11] == 5'h00) else $error("reserved bit set");
    par_act_a: assert property (
        1'b1 |=> par_err_act == $past(err_det.parity && cmd_bits[6]))
        else $error("parity action wrong");
    err_rep_a: assert property (
        1'b1 |=> {err_fatal_msg, err_nonfatal_msg}
        == $past({err_det.fatal, err_det.nonfatal} & {2{cmd_bits[8]}}))
        else $error("error report wrong");
    own_int_a: assert property (
        1'b1 |=> own_intx_msg == $past(own_int_req && !cmd_bits[10]))
        else $error("own intx wrong");
    dn_intx_a: assert property (
        1'b1 |=> dn_intx_out == $past(dn_intx_in)) else $error("intx forward wrong");
endmodule

/* verif/spc_rc_model.sv */
// root complex model issuing register accesses over axi4-lite
`timescale 1ns/1ps
module spc_rc_model
(
    // clock
    input wire logic        clk,
    // write channels
    output logic [11:0]     s_axi_awaddr,
    output logic            s_axi_awvalid,
    input wire logic        s_axi_awready,
    output logic [31:0]     s_axi_wdata,
    output logic [3:0]      s_axi_wstrb,
    output logic            s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    output logic            s_axi_bready,
    // read channels
    output logic [11:0]     s_axi_araddr,
    output logic            s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    output logic            s_axi_rready
);
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h0000000;
        s_axi_wdata = 32'h00000000;
    end

    // address and data are offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
            end
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
endmodule

/* verif/tb.sv */
// testbench for the switch port command register
`timescale 1ns/1ps
module tb
    import spc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic        prim_req_valid, prim_claim, prim_ignore, dn_req_valid, up_fwd, ur_cpl;
    logic        par_err_act, err_fatal_msg, err_nonfatal_msg;
    logic        own_int_req, own_intx_msg, dn_intx_in, dn_intx_out, irq;
    spc_req_s    prim_req, dn_req;
    spc_err_s    err_det;
    logic [15:0] cmd_bits, v;
    logic [10:0] ev = 11'h000;
    wire  [8:0]  ov;
    int          miscompares = 0;
    int          n_checks = 0;

    assign {prim_req_valid, prim_req, dn_req_valid, dn_req, err_det, own_int_req,
            dn_intx_in} = ev;
    assign ov = {prim_claim, prim_ignore, up_fwd, ur_cpl, par_err_act, err_fatal_msg,
                 err_nonfatal_msg, own_intx_msg, dn_intx_out};

    always #2.5 clk = ~clk;

    spc_command_reg u_dut (.*);
    spc_rc_model    u_rc (.*);

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] wr_r;
        u_rc.wr(a, d, 4'hf, wr_r);
        chk({30'h0, wr_r}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] rd_d;
        logic [1:0]  rd_r;
        u_rc.rd(a, rd_d, rd_r);
        chk(rd_d, ed);
        chk({30'h0, rd_r}, {30'h0, er});
    endtask

    // one-cycle event pulse, answers compared one cycle after it is taken
    task automatic fire(input logic [10:0] in, input logic [8:0] exp);
        ev <= in;
        @(posedge clk);
        ev <= 11'h000;
        @(posedge clk);
        chk({23'h0, ov}, {23'h0, exp});
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(SPC_OFF_CMD, 32'h0, SPC_RESP_OKAY);
        rd(12'h008, 32'h0, SPC_RESP_DECERR);
        wr(12'h00c, 32'hffffffff, SPC_RESP_DECERR);
        u_rc.wr(SPC_OFF_CMD, 32'hffffffff, 4'h2, r);
        chk({30'h0, r}, {30'h0, SPC_RESP_OKAY});
        rd(SPC_OFF_CMD, 32'h00000500, SPC_RESP_OKAY);
        for (int c = 0; c < 64; c++)
        begin
            v = {5'h0, c[5], 1'b0, c[4], 1'b0, c[3], 3'h0, c[2:0]};
            wr(SPC_OFF_CMD, {16'hffff, v | ~SPC_CMD_WMASK}, SPC_RESP_OKAY);
            rd(SPC_OFF_CMD, {16'h0, v}, SPC_RESP_OKAY);
            chk({16'h0, cmd_bits}, {16'h0, v});
            fire(11'h600, {c[0], !c[0], 7'h0});
            fire(11'h400, {c[1], !c[1], 7'h0});
            fire(11'h080, {2'h0, c[2], 6'h0});
            fire(11'h0e0, {2'h0, c[2], !c[2], 5'h0});
            fire(11'h01c, {4'h0, c[3], c[4], c[4], 2'h0});
            fire(11'h003, {7'h0, !c[5], 1'b1});
        end
        wr(SPC_OFF_CMD, 32'h0, SPC_RESP_OKAY);
        wr(SPC_OFF_STAT, 32'hf, SPC_RESP_OKAY);
        rd(SPC_OFF_STAT, 32'h0, SPC_RESP_OKAY);
        fire(11'h0a0, 9'h020);
        chk({31'h0, irq}, 32'h0);
        rd(SPC_OFF_STAT, 32'h1, SPC_RESP_OKAY);
        wr(SPC_OFF_MASK, 32'h1, SPC_RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        rd(SPC_OFF_MASK, 32'h1, SPC_RESP_OKAY);
        wr(SPC_OFF_STAT, 32'h1, SPC_RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        stop_test();
    end

    initial
    begin
        #50000;
        miscompares++;
        stop_test();
    end
endmodule

bind spc_command_reg spc_checker u_chk (.*);
